// ### src/pmrs_pkg.sv
// shared constants and carriers for the power mode and reset sequencer
package pmrs_pkg;
   localparam logic [7:0] PMC_ADDR = 8'h87;
   localparam logic [7:0] PMC_RESET = 8'h00;
   localparam int BIT_IDLE = 0;
   localparam int BIT_PDOWN = 1;
   localparam int BIT_FLAG_LO = 2;
   localparam int BIT_FLAG_HI = 3;
   localparam int BIT_RSVD = 4;
   localparam int BIT_SYNC_EN = 5;
   localparam int BIT_XMEM = 6;
   localparam int BIT_BAUD = 7;
   localparam logic [7:0] PMC_WMASK = 8'hEF;
   localparam logic [8:0] XTAL_START_TICKS = 9'h100;
   localparam logic [8:0] CLK6_START_TICKS = 9'h002;
   localparam int XMEM_INTERNAL_BYTES = 768;

   typedef enum {
      ST_PIN_RESET,
      ST_XTAL,
      ST_BOOST_SLOW,
      ST_CLK6,
      ST_BOOST_FAST,
      ST_RUN,
      ST_OFF,
      ST_OFF_RAMP
   } seq_state_type;

   // write/read port of the special function register space
   typedef struct packed {
      logic wr;
      logic rd;
      logic bit_access;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_type;

   // external pin states that depend on the power mode
   typedef struct packed {
      logic ale;
      logic prog_store_strobe;
      logic port0_pullup;
      logic port2_address;
   } pin_mode_type;
endpackage

// ### src/power_mode_reset_sequencer.sv
// power mode control register, reset sources and supply start-up sequencing
// How it works
// - off exit: supply up, reset, fetch zero
// - edge wake events dropped across off restart
// - pin states per idle, power-down, memory
// - control register at 87H, byte only
// - control register resets to zero
// - idle bit enters idle after instruction
// - power-down bit enters power-down after instruction
// - both bits written: power-down wins
// - bit seven doubles serial baud rate
// - bit six meaningless, keep it zero
// - bit five drives fetch toggle on pin, internal code only
// - bits three, two are plain flags
// - reset from pin or watchdog
// - reset output low during any reset
// - reset leaves internal RAM untouched
// - reset pin high holds SFRs, strobes high
// - reset pin low starts start-up sequence
// - watchdog resets only when enabled, expired
// - internal reset on off-mode restart
// - pin pulse resets SFRs and converter registers
// - wait 256 slow crystal clocks first
// - boost to 1.7 V, slow clock, pmos off
// - any interrupt clears idle bit, external interrupt clears power-down bit
// - supply at threshold sets stable, runs CPU
`timescale 1ns/10ps
module power_mode_reset_sequencer
   import pmrs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // cpu register access
   input pmrs_pkg::sfr_req_type sfr_req,
   input wire logic instr_end,
   input wire logic fetch_strobe,
   output logic [7:0] sfr_rdata,
   // interrupts that end the low power modes
   input wire logic any_irq_taken,
   input wire logic ext_irq_taken,
   // reset sources
   input wire logic reset_input_pin,
   input wire logic wdt_enable,
   input wire logic wdt_expire,
   // converter status and off-mode events
   input wire logic xtal_clk_pin,
   input wire logic off_request,
   input wire logic wake_event,
   input wire logic supply_low_ok,
   input wire logic supply_ok,
   // memory configuration
   input wire logic ext_memory,
   // outputs
   output logic reset_output_n,
   output logic sfr_reset,
   output logic conv_reg_reset,
   output logic edge_irq_drop,
   output logic fetch_from_zero,
   output logic stable_flag,
   output logic cpu_run,
   output logic idle_active,
   output logic powerdown_active,
   output logic baud_doubler,
   output logic fetch_toggle_signal,
   output logic boost_slow,
   output logic pmos_off,
   output logic boost_fast,
   output pmrs_pkg::pin_mode_type pin_mode
);
   import pmrs_pkg::*;

   function automatic logic filt(input logic s2, input logic s3, input logic old);
      filt = (s2 == s3) ? s3 : old;
   endfunction

   logic [2:0] rst_sync_q;
   logic [2:0] xtal_sync_q;
   logic rst_pin_q;
   logic xtal_q;
   logic xtal_prev_q;
   logic xtal_tick;
   seq_state_type state_q;
   seq_state_type state_d;
   logic [8:0] tick_cnt_q;
   logic [7:0] pmc_q;
   logic in_reset;
   logic pmc_wr;
   logic wdt_reset;

   // three stage sampling: second and third must agree before a change counts
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 3'h0;
         xtal_sync_q <= 3'h0;
         rst_pin_q <= 1'b0;
         xtal_q <= 1'b0;
         xtal_prev_q <= 1'b0;
      end else begin
         rst_sync_q <= {rst_sync_q[1:0], reset_input_pin};
         xtal_sync_q <= {xtal_sync_q[1:0], xtal_clk_pin};
         rst_pin_q <= filt(rst_sync_q[1], rst_sync_q[2], rst_pin_q);
         xtal_q <= filt(xtal_sync_q[1], xtal_sync_q[2], xtal_q);
         xtal_prev_q <= xtal_q;
      end
   end

   assign xtal_tick = xtal_q & ~xtal_prev_q;
   assign wdt_reset = wdt_enable & wdt_expire;
   // register is byte wide only; bit-addressed writes are ignored
   assign pmc_wr = sfr_req.wr & ~sfr_req.bit_access & (sfr_req.addr == PMC_ADDR);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_PIN_RESET: begin
            if (!rst_pin_q) begin
               state_d = ST_XTAL;
            end
         end
         ST_XTAL: begin
            if (xtal_tick && tick_cnt_q == XTAL_START_TICKS - 9'h001) begin
               state_d = ST_BOOST_SLOW;
            end
         end
         ST_BOOST_SLOW: begin
            if (supply_low_ok) begin
               state_d = ST_CLK6;
            end
         end
         ST_CLK6: begin
            if (xtal_tick && tick_cnt_q == CLK6_START_TICKS - 9'h001) begin
               state_d = ST_BOOST_FAST;
            end
         end
         ST_BOOST_FAST: begin
            if (supply_ok) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (off_request) begin
               state_d = ST_OFF;
            end
         end
         ST_OFF: begin
            if (wake_event) begin
               state_d = ST_OFF_RAMP;
            end
         end
         ST_OFF_RAMP: begin
            // supply first; reset is already held through the ramp, start-up restarts once it is back at level
            if (supply_ok) begin
               state_d = ST_XTAL;
            end
         end
         default: state_d = ST_PIN_RESET;
      endcase
      // pin overrides any step of the sequence; watchdog only overrides run
      if (rst_pin_q) begin
         state_d = ST_PIN_RESET;
      end else if (wdt_reset && state_q == ST_RUN) begin
         state_d = ST_XTAL;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_PIN_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_q <= 9'h000;
      end else if (state_d != state_q) begin
         tick_cnt_q <= 9'h000;
      end else if (xtal_tick) begin
         tick_cnt_q <= tick_cnt_q + 9'h001;
      end
   end

   assign in_reset = (state_q != ST_RUN) && (state_q != ST_OFF);

   // reset indications; RAM has no reset path here on purpose
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reset_output_n <= 1'b0;
         sfr_reset <= 1'b1;
         conv_reg_reset <= 1'b1;
         edge_irq_drop <= 1'b0;
         fetch_from_zero <= 1'b0;
         stable_flag <= 1'b0;
         cpu_run <= 1'b0;
      end else begin
         reset_output_n <= (state_d == ST_RUN) || (state_d == ST_OFF);
         sfr_reset <= (state_d != ST_RUN) && (state_d != ST_OFF);
         conv_reg_reset <= (state_d == ST_PIN_RESET);
         edge_irq_drop <= (state_d == ST_XTAL) && (state_q == ST_OFF_RAMP);
         fetch_from_zero <= (state_d == ST_RUN) && (state_q != ST_RUN);
         stable_flag <= (state_d == ST_RUN) || (state_d == ST_OFF);
         cpu_run <= (state_d == ST_RUN);
      end
   end

   // converter drive during start-up
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         boost_slow <= 1'b0;
         pmos_off <= 1'b1;
         boost_fast <= 1'b0;
      end else begin
         boost_slow <= (state_d == ST_BOOST_SLOW) || (state_d == ST_OFF_RAMP);
         pmos_off <= (state_d != ST_BOOST_FAST) && (state_d != ST_RUN);
         boost_fast <= (state_d == ST_BOOST_FAST) || (state_d == ST_RUN);
      end
   end

   // control register; a software write wins over a same-cycle interrupt clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pmc_q <= PMC_RESET;
      end else if (in_reset) begin
         pmc_q <= PMC_RESET;
      end else if (pmc_wr) begin
         pmc_q <= sfr_req.wdata & PMC_WMASK;
         if (sfr_req.wdata[BIT_PDOWN]) begin
            pmc_q[BIT_IDLE] <= 1'b0;
         end
      end else begin
         if (any_irq_taken) begin
            pmc_q[BIT_IDLE] <= 1'b0;
         end
         if (ext_irq_taken) begin
            pmc_q[BIT_PDOWN] <= 1'b0;
         end
      end
   end

   // modes start only when the writing instruction has ended
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         idle_active <= 1'b0;
         powerdown_active <= 1'b0;
      end else begin
         if (!pmc_q[BIT_IDLE] || in_reset) begin
            idle_active <= 1'b0;
         end else if (instr_end) begin
            idle_active <= 1'b1;
         end
         if (!pmc_q[BIT_PDOWN] || in_reset) begin
            powerdown_active <= 1'b0;
         end else if (instr_end) begin
            powerdown_active <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         baud_doubler <= 1'b0;
         sfr_rdata <= 8'h00;
      end else begin
         baud_doubler <= pmc_q[BIT_BAUD];
         sfr_rdata <= (sfr_req.rd && sfr_req.addr == PMC_ADDR) ? pmc_q : 8'h00;
      end
   end

   // fetch sync toggles per fetch, only with internal code access
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fetch_toggle_signal <= 1'b0;
      end else if (pmc_q[BIT_SYNC_EN] && !ext_memory && fetch_strobe) begin
         fetch_toggle_signal <= ~fetch_toggle_signal;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_mode <= '{ale: 1'b1, prog_store_strobe: 1'b1, port0_pullup: 1'b0,
                       port2_address: 1'b0};
      end else if (state_d == ST_PIN_RESET || in_reset) begin
         pin_mode <= '{ale: 1'b1, prog_store_strobe: 1'b1, port0_pullup: 1'b0,
                       port2_address: 1'b0};
      end else if (powerdown_active) begin
         pin_mode <= '{ale: 1'b0, prog_store_strobe: 1'b0, port0_pullup: 1'b1,
                       port2_address: ext_memory};
      end else if (idle_active) begin
         pin_mode <= '{ale: 1'b1, prog_store_strobe: 1'b1, port0_pullup: ext_memory,
                       port2_address: ext_memory};
      end else begin
         pin_mode <= '{ale: 1'b0, prog_store_strobe: 1'b1, port0_pullup: 1'b0,
                       port2_address: ext_memory};
      end
   end

   // the reset output is registered from the next state, so it matches the current state
   AST_RESET_OUTPUT_N_LOW: assert property (@(posedge clk) disable iff (!resetn)
      in_reset |-> !reset_output_n)
      else $error("reset output high during reset");
   AST_PIN_HOLDS: assert property (@(posedge clk) disable iff (!resetn)
      rst_pin_q |=> state_q == ST_PIN_RESET ##0 pin_mode.ale && pin_mode.prog_store_strobe)
      else $error("reset pin high but sequencer not held");
   AST_PD_WINS: assert property (@(posedge clk) disable iff (!resetn)
      pmc_wr && !in_reset && sfr_req.wdata[1:0] == 2'h3 |=> pmc_q[1:0] == 2'h2)
      else $error("idle kept when both mode bits written");
   AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!resetn)
      !pmc_q[BIT_RSVD])
      else $error("reserved bit set");
   AST_BIT_WR_IGNORED: assert property (@(posedge clk) disable iff (!resetn)
      sfr_req.wr && sfr_req.bit_access && !any_irq_taken && !ext_irq_taken && !in_reset
      |=> $stable(pmc_q))
      else $error("bit-addressed write changed register");
   AST_IDLE_ENTRY: assert property (@(posedge clk) disable iff (!resetn)
      pmc_q[BIT_IDLE] && instr_end && !in_reset && !idle_active |=> idle_active)
      else $error("idle not entered");
   AST_IRQ_ENDS_IDLE: assert property (@(posedge clk) disable iff (!resetn)
      any_irq_taken && !pmc_wr |=> !pmc_q[BIT_IDLE] ##1 !idle_active)
      else $error("interrupt did not end idle");
   AST_SLOW_BOOST: assert property (@(posedge clk) disable iff (!resetn)
      state_q == ST_BOOST_SLOW |-> boost_slow && pmos_off)
      else $error("slow boost drive wrong");
   AST_PD_PINS: assert property (@(posedge clk) disable iff (!resetn)
      powerdown_active && !in_reset && !rst_pin_q
      |=> !pin_mode.ale && !pin_mode.prog_store_strobe && pin_mode.port0_pullup)
      else $error("power-down pin states wrong");
   AST_WDT_GATED: assert property (@(posedge clk) disable iff (!resetn)
      state_q == ST_RUN && !rst_pin_q && !off_request && !wdt_enable |=> state_q == ST_RUN)
      else $error("reset without enabled watchdog");
   AST_STABLE_RUN: assert property (@(posedge clk) disable iff (!resetn)
      state_q == ST_BOOST_FAST && supply_ok && !rst_pin_q |=> cpu_run && stable_flag)
      else $error("start not released at threshold");

   COV_OFF_RESTART: cover property (@(posedge clk) disable iff (!resetn)
      state_q == ST_OFF_RAMP ##1 edge_irq_drop);
   COV_PIN_START: cover property (@(posedge clk) disable iff (!resetn)
      state_q == ST_BOOST_FAST ##1 fetch_from_zero);
   COV_PD_ENTRY: cover property (@(posedge clk) disable iff (!resetn)
      $rose(powerdown_active));
   COV_WDT: cover property (@(posedge clk) disable iff (!resetn)
      state_q == ST_RUN && wdt_reset ##1 !reset_output_n);
endmodule

// ### verif/supply_model.sv
// behavioural model of the crystal, battery converter supply and reset network
`timescale 1ns/10ps
module supply_model #(
   parameter int XTAL_HALF = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // converter drive seen from the device, supply collapse and pace controls from the bench
   input wire logic boost_slow,
   input wire logic boost_fast,
   input wire logic drop,
   input wire logic slow,
   // outputs towards the device
   output logic xtal_clk_pin,
   output logic supply_low_ok,
   output logic supply_ok
);
   logic [2:0] div_q;
   logic [4:0] lvl_q;
   logic [1:0] pace_q;
   // crystal runs free in every mode, but far faster than real so start-up fits the run
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_q <= 3'h0;
         xtal_clk_pin <= 1'b0;
      end else if (div_q == 3'(XTAL_HALF - 1)) begin
         div_q <= 3'h0;
         xtal_clk_pin <= ~xtal_clk_pin;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end
   // supply collapses on off, watchdog or pin reset and rises only while boosted
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lvl_q <= 5'h00;
         pace_q <= 2'h0;
      end else begin
         pace_q <= pace_q + 2'h1;
         if (drop) begin
            lvl_q <= 5'h00;
         end else if ((boost_slow | boost_fast) && (!slow || pace_q == 2'h0) && lvl_q < 5'h14) begin
            lvl_q <= lvl_q + 5'h01;
         end
      end
   end
   assign supply_low_ok = lvl_q >= 5'h08;
   assign supply_ok = lvl_q >= 5'h10;
endmodule

// ### verif/tb_top.sv
// self-checking bench for the power mode and reset sequencer
`timescale 1ns/10ps
module tb_top;
   import pmrs_pkg::*;
   logic clk, resetn, reset_input_pin, wdt_enable, ext_memory, slow, t;
   logic instr_end, fetch_strobe, any_irq_taken, ext_irq_taken, wdt_expire, off_request, wake_event;
   logic xtal_clk_pin, supply_low_ok, supply_ok, reset_output_n, sfr_reset, conv_reg_reset;
   logic edge_irq_drop, fetch_from_zero, stable_flag, cpu_run, idle_active, powerdown_active;
   logic baud_doubler, fetch_toggle_signal, boost_slow, pmos_off, boost_fast;
   logic [6:0] pl;
   logic [4:0] xt_dly;
   logic [7:0] sfr_rdata, a, expv;
   logic [31:0] seed, v;
   sfr_req_type sfr_req;
   pin_mode_type pin_mode;
   int mismatches, cmp_count, xt_cnt;
   assign {instr_end, fetch_strobe, any_irq_taken, ext_irq_taken, wdt_expire, off_request,
      wake_event} = pl;
   power_mode_reset_sequencer i_power_mode_reset_sequencer (.clk, .resetn, .sfr_req,
      .instr_end, .fetch_strobe, .sfr_rdata, .any_irq_taken, .ext_irq_taken,
      .reset_input_pin, .wdt_enable, .wdt_expire, .xtal_clk_pin, .off_request, .wake_event,
      .supply_low_ok, .supply_ok, .ext_memory, .reset_output_n, .sfr_reset, .conv_reg_reset,
      .edge_irq_drop, .fetch_from_zero, .stable_flag, .cpu_run, .idle_active,
      .powerdown_active, .baud_doubler, .fetch_toggle_signal, .boost_slow, .pmos_off,
      .boost_fast, .pin_mode);
   supply_model i_supply_model (.clk, .resetn, .boost_slow, .boost_fast,
      .drop(off_request | reset_input_pin | (wdt_enable & wdt_expire)), .slow,
      .xtal_clk_pin, .supply_low_ok, .supply_ok);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // count crystal rises once past the pin sampling delay, so a rise still in flight
   // when a start-up restarts is credited to the new start-up, as the sequencer credits it
   always @(posedge clk) begin
      xt_dly <= {xt_dly[3:0], xtal_clk_pin};
      if (xt_dly[3] && !xt_dly[4]) xt_cnt++;
   end
   // register image after a byte write: reserved bit dropped, power-down beats idle
   function automatic logic [7:0] exp_pmc(input logic [7:0] d);
      exp_pmc = d & PMC_WMASK;
      if (d[BIT_PDOWN]) exp_pmc[BIT_IDLE] = 1'b0;
   endfunction
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic bit hit(input int sel);
      case (sel)
         1: return boost_slow === 1'b1;
         2: return edge_irq_drop === 1'b1;
         3: return fetch_from_zero === 1'b1;
         4: return idle_active === 1'b1;
         5: return powerdown_active === 1'b1;
         6: return reset_output_n === 1'b0;
         default: return idle_active === 1'b0 && powerdown_active === 1'b0;
      endcase
   endfunction
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_for(input int sel, input int lim);
      int n;
      n = 0;
      while (!hit(sel)) begin
         cyc(1);
         n++;
         if (n > lim) begin
            mismatches++;
            $display("wrong value at %0t: no event %0d", $time, sel);
            summarize();
         end
      end
   endtask
   // one bus cycle; read data is valid right after the edge that drops the strobe
   task automatic sfr_op(input logic wr, input logic ba, input logic [7:0] ad,
      input logic [7:0] d);
      @(posedge clk);
      sfr_req.wr <= wr;
      sfr_req.rd <= !wr;
      sfr_req.bit_access <= ba;
      sfr_req.addr <= ad;
      sfr_req.wdata <= d;
      @(posedge clk);
      sfr_req.wr <= 1'b0;
      sfr_req.rd <= 1'b0;
      #1;
   endtask
   task automatic pulse(input logic [6:0] m);
      @(posedge clk);
      pl <= m;
      @(posedge clk);
      pl <= 7'h00;
      #1;
   endtask
   task automatic startup();
      xt_cnt = 0;
      wait_for(1, 4000);
      chk(8'(xt_cnt >= 256 && xt_cnt <= 258), 8'h01);
      chk({6'h0, pmos_off, reset_output_n}, 8'h02);
      wait_for(3, 4000);
      chk({3'h0, boost_fast, pmos_off, stable_flag, cpu_run, reset_output_n}, 8'h17);
      sfr_op(1'b0, 1'b0, PMC_ADDR, 8'h00);
      chk(sfr_rdata, PMC_RESET);
   endtask
   initial begin
      seed = 32'h1FF8;
      resetn = 1'b0;
      sfr_req = '0;
      pl = 7'h00;
      {reset_input_pin, wdt_enable, ext_memory, slow} = 4'h0;
      {mismatches, cmp_count, xt_cnt} = '0;
      cyc(10);
      chk({3'h0, reset_output_n, pin_mode}, 8'h0C);
      @(posedge clk);
      resetn <= 1'b1;
      startup();
      expv = PMC_RESET;
      // bits 0, 1, 5 and 6 stay low so traffic never enters a mode
      for (int i = 0; i < 24; i++) begin
         v = rnd();
         a = v[9] ? PMC_ADDR : 8'h88 + {3'h0, v[14:10]};
         if (!v[8] && a == PMC_ADDR) expv = exp_pmc(v[7:0] & 8'h9C);
         sfr_op(1'b1, v[8], a, v[7:0] & 8'h9C);
         sfr_op(1'b0, 1'b0, PMC_ADDR, 8'h00);
         chk(sfr_rdata, expv);
         chk({7'h0, baud_doubler}, {7'h0, expv[7]});
         sfr_op(1'b0, 1'b0, a, 8'h00);
         if (a != PMC_ADDR) chk(sfr_rdata, 8'h00);
      end
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         ext_memory <= m[0];
         slow <= m[0];
         sfr_op(1'b1, 1'b0, PMC_ADDR, 8'h0D);
         pulse(7'h40);
         wait_for(4, 10);
         cyc(2);
         chk({4'h0, pin_mode}, m ? 8'h0F : 8'h0C);
         pulse(7'h10);
         wait_for(7, 10);
         sfr_op(1'b0, 1'b0, PMC_ADDR, 8'h00);
         chk(sfr_rdata, 8'h0C);
         sfr_op(1'b1, 1'b0, PMC_ADDR, 8'h03);
         sfr_op(1'b0, 1'b0, PMC_ADDR, 8'h00);
         chk(sfr_rdata, 8'h02);
         pulse(7'h40);
         wait_for(5, 10);
         cyc(2);
         chk({3'h0, idle_active, pin_mode}, m ? 8'h03 : 8'h02);
         pulse(7'h08);
         wait_for(7, 10);
         sfr_op(1'b0, 1'b0, PMC_ADDR, 8'h00);
         chk(sfr_rdata, 8'h00);
      end
      // test-mode access only: software proper never sets the sync enable
      @(posedge clk);
      ext_memory <= 1'b0;
      sfr_op(1'b1, 1'b0, PMC_ADDR, 8'h20);
      cyc(1);
      t = fetch_toggle_signal;
      pulse(7'h20);
      cyc(1);
      chk({7'h0, fetch_toggle_signal}, {7'h0, ~t});
      sfr_op(1'b1, 1'b0, PMC_ADDR, 8'h00);
      pulse(7'h04);
      cyc(4);
      chk({7'h0, reset_output_n}, 8'h01);
      @(posedge clk);
      wdt_enable <= 1'b1;
      pulse(7'h04);
      wait_for(6, 10);
      chk({6'h0, conv_reg_reset, sfr_reset}, 8'h01);
      startup();
      pulse(7'h02);
      cyc(6);
      pulse(7'h01);
      wait_for(2, 3000);
      chk({7'h0, reset_output_n}, 8'h00);
      wait_for(3, 6000);
      chk({6'h0, stable_flag, cpu_run}, 8'h03);
      @(posedge clk);
      reset_input_pin <= 1'b1;
      wait_for(6, 10);
      cyc(20);
      chk({2'h0, conv_reg_reset, sfr_reset, pin_mode}, 8'h3C);
      sfr_op(1'b1, 1'b0, PMC_ADDR, 8'h0C);
      @(posedge clk);
      reset_input_pin <= 1'b0;
      startup();
      summarize();
   end
endmodule
